// ### logic/imd_decoder.sv
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module imd_decoder
  import imd_pkg::*;
#(
  parameter int DEB_CYC = IMD_DEBOUNCE_CYC
)(
  // bus
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // contacts
  input  wire logic        run_stop_input,
  input  wire logic        direction_input,
  input  wire logic        reference_select_input,
  input  wire logic        analog_in_one,
  input  wire logic        enable_input,
  // drive commands
  output imd_cmd_t         cmd
);

  // ****************************************
  // synchronise and debounce
  // ****************************************
  localparam int NIN = 5;
  localparam int CW  = $clog2(DEB_CYC + 1);
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q, s2_q, deb_q, deb_d, prev_q;
  logic [CW-1:0]  cnt_q [NIN];
  logic [CW-1:0]  cnt_d [NIN];
  assign raw = {enable_input, analog_in_one, reference_select_input,
                direction_input, run_stop_input};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_deb
      always_comb
      begin
        deb_d[gi] = deb_q[gi];
        cnt_d[gi] = '0;
        if (s2_q[gi] != deb_q[gi])
        begin
          cnt_d[gi] = cnt_q[gi] + CW'(1);
          if (cnt_q[gi] == CW'(DEB_CYC - 1))
          begin
            deb_d[gi] = s2_q[gi];
            cnt_d[gi] = '0;
          end
        end
      end
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cnt_q[gi] <= '0;
        else
          cnt_q[gi] <= cnt_d[gi];
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      deb_q  <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q   <= raw;
      s2_q   <= s1_q;
      deb_q  <= deb_d;
      prev_q <= deb_q;
    end
  end

  logic i1, i2, i3, i4, en;
  logic r1, r2, f2, f4, r3f, both_r;
  assign i1 = deb_q[0];
  assign i2 = deb_q[1];
  assign i3 = deb_q[2];
  assign i4 = deb_q[3];
  assign en = deb_q[4];
  assign r1 = i1 & ~prev_q[0];
  assign r2 = i2 & ~prev_q[1];
  assign f4 = ~i4 & prev_q[3];
  assign both_r = i1 & i4 & ~(prev_q[0] & prev_q[3]);
  assign f2 = ~i2 & prev_q[1];
  assign r3f = ~i3 & prev_q[2];

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_q, ctrl_d;
  logic        ph_wr_q;
  logic [7:0]  ph_addr_q;
  logic [31:0] rdata_d;
  logic        acc;

  assign acc = hsel & hready & htrans[1];

  logic [3:0] src, macro;
  logic       autostart, kpd_immed, kpd_spd, trip_fmt;
  logic       kstart, kstop, fb_start, trip_clr;
  assign src       = ctrl_q[IMD_CTRL_SRC_LSB +: 4];
  assign macro     = ctrl_q[IMD_CTRL_MACRO_LSB +: 4];
  assign autostart = ctrl_q[IMD_CTRL_AUTO_BIT];
  assign kpd_immed = ctrl_q[IMD_CTRL_KPDM_BIT];
  assign kpd_spd   = ctrl_q[IMD_CTRL_KSPD_BIT];
  assign trip_fmt  = ctrl_q[IMD_CTRL_TFMT_BIT];
  assign kstart    = ctrl_q[IMD_CTRL_KSTA_BIT];
  assign kstop     = ctrl_q[IMD_CTRL_KSTO_BIT];
  assign fb_start  = ctrl_q[IMD_CTRL_FBST_BIT];
  assign trip_clr  = ctrl_q[IMD_CTRL_TCLR_BIT];

  imd_state_t st_q, st_d;
  logic       rev_q, rev_d;
  logic [1:0] trip_q, trip_d;
  logic       boot_q;

  always_comb
  begin
    ctrl_d = ctrl_q;
    ctrl_d[IMD_CTRL_KSTA_BIT] = 1'b0;
    ctrl_d[IMD_CTRL_KSTO_BIT] = 1'b0;
    ctrl_d[IMD_CTRL_FBST_BIT] = 1'b0;
    ctrl_d[IMD_CTRL_TCLR_BIT] = 1'b0;
    if (ph_wr_q && ph_addr_q == IMD_CTRL_ADDR)
      ctrl_d = hwdata;
    // read data launched in the address phase stands through the data phase;
    // ctrl_d forwards a write whose data phase ends at the same edge
    rdata_d = hrdata;
    if (acc && !hwrite)
    begin
      case (haddr[7:0])
        IMD_CTRL_ADDR:   rdata_d = ctrl_d;
        IMD_STATUS_ADDR: rdata_d = {26'h0, trip_q, rev_q, boot_q, st_q};
        IMD_INPUT_ADDR:  rdata_d = {27'h0, deb_q};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q    <= IMD_CTRL_RESET;
      ph_wr_q   <= 1'b0;
      ph_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      ph_wr_q   <= acc & hwrite;
      ph_addr_q <= haddr[7:0];
      hrdata    <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  logic fr_macro, push_macro, startfr_macro, trip_macro;
  logic stop_lvl, go, go_rev, go_dir_valid, fast, ext_trip, pre;
  always_comb
  begin
    fr_macro      = (macro == IMD_MAC_RUN_FR) || (macro == IMD_MAC_TRIP_FR);
    startfr_macro = (macro == IMD_MAC_START_FR);
    push_macro    = (macro == IMD_MAC_PUSH);
    trip_macro    = (macro == IMD_MAC_TRIP_DIR) || (macro == IMD_MAC_TRIP_FR);
    stop_lvl      = 1'b0;
    go            = 1'b0;
    go_rev        = rev_q;
    go_dir_valid  = 1'b0;
    fast          = 1'b0;
    ext_trip      = trip_macro & r3f;
    pre           = i3;
    if (src == IMD_SRC_KEYPAD)
    begin
      stop_lvl = ~en | kstop;
      go       = en & (kpd_immed | kstart);
    end
    else if (fr_macro)
    begin
      stop_lvl     = ~i1 & ~i2;
      go           = i1 ^ i2;
      go_rev       = i2;
      go_dir_valid = 1'b1;
      fast         = i1 & i2;
    end
    else if (startfr_macro)
    begin
      stop_lvl     = ~i3;
      fast         = (r1 & i2) | (r2 & i1) | f4;
      go           = i3 & (r1 ^ r2) & ~fast;
      go_rev       = r2;
      go_dir_valid = go;
      ext_trip     = 1'b0;
      pre          = 1'b0;
    end
    else if (push_macro)
    begin
      stop_lvl = f2;
      go       = i2 & (r1 | both_r);
      fast     = 1'b0;
    end
    else
    begin
      stop_lvl     = ~i1;
      go           = i1;
      go_rev       = i2;
      go_dir_valid = 1'b1;
    end
    if (src > IMD_SRC_KEYPAD)
    begin
      // fieldbus: the start pulse counts only with enable already present
      stop_lvl = ~en;
      go       = en & fb_start;
    end
  end

  // ****************************************
  // power-on window
  // ****************************************
  // held open until the debounced contacts have settled, so that a run
  // contact closed through power-up is seen before the window can close
  localparam int PW     = CW + 2;
  localparam int SETTLE = DEB_CYC + 4;
  logic [PW-1:0] pwr_q, pwr_d;
  logic          boot_d;

  always_comb
  begin
    pwr_d  = pwr_q;
    boot_d = boot_q;
    if (pwr_q != PW'(SETTLE))
      pwr_d = pwr_q + PW'(1);
    else if (!go)
      boot_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwr_q  <= '0;
      boot_q <= 1'b1;
    end
    else
    begin
      pwr_q  <= pwr_d;
      boot_q <= boot_d;
    end
  end

  // ****************************************
  // run state
  // ****************************************
  always_comb
  begin
    st_d   = st_q;
    rev_d  = go_dir_valid ? go_rev : rev_q;
    trip_d = trip_q;
    if (ext_trip)
    begin
      st_d   = IMD_TRIPPED;
      trip_d = trip_fmt ? IMD_TRIP_THERM : IMD_TRIP_EXT;
    end
    else if (st_q == IMD_TRIPPED)
    begin
      if (trip_clr)
      begin
        st_d   = IMD_STOPPED;
        trip_d = IMD_TRIP_NONE;
      end
    end
    else if (fast)
      st_d = IMD_FASTSTOP;
    else if (stop_lvl)
      st_d = IMD_STOPPED;
    else if (boot_q && !autostart && go)
      st_d = IMD_STOPPED;
    else if (go)
      st_d = IMD_RUNNING;
    else if (st_q == IMD_FASTSTOP)
      st_d = IMD_STOPPED;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q   <= IMD_STOPPED;
      rev_q  <= 1'b0;
      trip_q <= IMD_TRIP_NONE;
      cmd    <= '0;
    end
    else
    begin
      st_q   <= st_d;
      rev_q  <= rev_d;
      trip_q <= trip_d;
      cmd.run        <= (st_d == IMD_RUNNING);
      cmd.reverse    <= rev_d;
      cmd.fast_stop  <= (st_d == IMD_FASTSTOP);
      cmd.use_preset <= pre;
      cmd.kpd_speed  <= (src == IMD_SRC_KEYPAD) & kpd_spd;
      cmd.trip_code  <= trip_d;
    end
  end

endmodule : imd_decoder

// ### logic/imd_pkg.sv
package imd_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] IMD_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] IMD_STATUS_ADDR = 8'h04;
  localparam logic [7:0] IMD_INPUT_ADDR  = 8'h08;

  // ctrl field positions
  localparam int IMD_CTRL_SRC_LSB   = 0;
  localparam int IMD_CTRL_MACRO_LSB = 4;
  localparam int IMD_CTRL_AUTO_BIT  = 8;
  localparam int IMD_CTRL_KPDM_BIT  = 9;
  localparam int IMD_CTRL_KSPD_BIT  = 10;
  localparam int IMD_CTRL_TFMT_BIT  = 11;
  localparam int IMD_CTRL_KSTA_BIT  = 12;
  localparam int IMD_CTRL_KSTO_BIT  = 13;
  localparam int IMD_CTRL_FBST_BIT  = 14;
  localparam int IMD_CTRL_TCLR_BIT  = 15;

  localparam logic [31:0] IMD_CTRL_RESET = 32'h0000_0000;

  // control sources
  localparam logic [3:0] IMD_SRC_TERMINAL = 4'h0;
  localparam logic [3:0] IMD_SRC_KEYPAD   = 4'h1;

  // macro numbers
  localparam logic [3:0] IMD_MAC_RUN_DIR  = 4'h0;
  localparam logic [3:0] IMD_MAC_RUN_FR   = 4'h5;
  localparam logic [3:0] IMD_MAC_TRIP_DIR = 4'h6;
  localparam logic [3:0] IMD_MAC_TRIP_FR  = 4'h7;
  localparam logic [3:0] IMD_MAC_START_FR = 4'h9;
  localparam logic [3:0] IMD_MAC_PUSH     = 4'hA;

  // debounce
  localparam int IMD_DEBOUNCE_US = 10;
  localparam int IMD_CLK_MHZ     = 25;
  localparam int IMD_DEBOUNCE_CYC = IMD_DEBOUNCE_US * IMD_CLK_MHZ;

  // trip codes
  localparam logic [1:0] IMD_TRIP_NONE = 2'h0;
  localparam logic [1:0] IMD_TRIP_EXT  = 2'h1;
  localparam logic [1:0] IMD_TRIP_THERM = 2'h2;

  typedef enum logic [1:0] {IMD_STOPPED, IMD_RUNNING, IMD_FASTSTOP, IMD_TRIPPED} imd_state_t;

  typedef struct packed {
    logic       run;
    logic       reverse;
    logic       fast_stop;
    logic       use_preset;
    logic       kpd_speed;
    logic [1:0] trip_code;
  } imd_cmd_t;

endpackage : imd_pkg

// ### tb/imd_monitor.sv
`timescale 1ns/1ps
module imd_monitor
  import imd_pkg::*;
#(
  parameter int DEB_CYC = IMD_DEBOUNCE_CYC
)(
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // contacts and commands
  input wire logic        run_stop_input,
  input wire logic        direction_input,
  input wire logic        reference_select_input,
  input wire imd_cmd_t    cmd
);
  logic        wr_q;
  logic [11:0] ctl_q;
  wire         t0  = ctl_q[7:0] == 8'h00;
  wire         t5  = ctl_q[7:0] == 8'h50;
  wire         m6  = ctl_q[7:4] == IMD_MAC_TRIP_DIR;
  wire         m10 = ctl_q[7:0] == 8'hA0;

  // ****
  // shadow of the control register
  // ****
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q  <= 1'b0;
      ctl_q <= 12'h000;
    end
    else
    begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == IMD_CTRL_ADDR;
      if (wr_q)
        ctl_q <= hwdata[11:0];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus wait or error");
  property p_stop; (t0 && !run_stop_input)[*8] |-> !cmd.run; endproperty
  a_stop: assert property (p_stop) else $error("runs while open");
  property p_run; t0 && $rose(cmd.run) |-> $past(run_stop_input, 2); endproperty
  a_run: assert property (p_run) else $error("run without contact");
  property p_ref; (t0 && $stable(reference_select_input))[*8]
    |-> cmd.use_preset == reference_select_input; endproperty
  a_ref: assert property (p_ref) else $error("wrong reference");
  property p_trip; (m6 && !reference_select_input)[*8]
    |-> cmd.trip_code == (ctl_q[11] ? IMD_TRIP_THERM : IMD_TRIP_EXT); endproperty
  a_trip: assert property (p_trip) else $error("trip code wrong");
  property p_fwd; (t5 && run_stop_input && !direction_input)[*8]
    |-> cmd.run && !cmd.reverse; endproperty
  a_fwd: assert property (p_fwd) else $error("no forward run");
  property p_fast; t5 && $rose(run_stop_input && direction_input)
    |-> ##[1:12] cmd.fast_stop; endproperty
  a_fast: assert property (p_fast) else $error("no fast stop");
  property p_start; m10 && $rose(cmd.run) |-> $past(direction_input, 2); endproperty
  a_start: assert property (p_start) else $error("start with stop open");

  c_run: cover property (t0 && $rose(cmd.run));
  c_trip: cover property (m6 && cmd.trip_code != IMD_TRIP_NONE);
  c_fast: cover property (t5 && cmd.fast_stop);
endmodule : imd_monitor

bind imd_decoder imd_monitor #(.DEB_CYC(DEB_CYC)) u_mon (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .run_stop_input, .direction_input, .reference_select_input, .cmd
);

// ### tb/imd_switches.sv
`timescale 1ns/1ps
module imd_switches (
  // clock and demanded levels
  input wire logic       hclk,
  input wire logic [4:0] want,
  // contact levels
  output logic     [4:0] pins = 5'h00
);
  // contacts lag the operator by one cycle
  always_ff @(posedge hclk)
    pins <= want;
endmodule : imd_switches

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import imd_pkg::*;
  logic        hclk;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        rdy;
  logic        hresp;
  logic [4:0]  want    = 5'h00;
  logic [4:0]  pins;
  logic        fs;
  imd_cmd_t    cmd;
  int          err_count = 0;
  int          total_checks = 0;

  imd_switches sw (.hclk, .want, .pins);
  imd_decoder #(.DEB_CYC(2)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(rdy), .hrdata, .hreadyout(rdy), .hresp, .run_stop_input(pins[0]),
    .direction_input(pins[1]), .reference_select_input(pins[2]),
    .analog_in_one(pins[3]), .enable_input(pins[4]), .cmd
  );

  // ****
  // tasks
  // ****
  task check(input logic [31:0] s, input logic [31:0] e, input string n);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // sets the contacts and lets them pass sync and debounce
  task hold(input logic [4:0] v);
    want <= v;
    repeat (10) @(posedge hclk);
  endtask : hold

  // sets the contacts and records any fast-stop pulse over 12 cycles
  task catch_fast(input logic [4:0] v);
    fs = 1'b0;
    want <= v;
    repeat (12)
    begin
      @(posedge hclk);
      fs = fs | cmd.fast_stop;
    end
  endtask : catch_fast

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial
  begin
    repeat (5000) @(posedge hclk);
    err_count++;
    finish_test;
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, IMD_CTRL_ADDR, 32'h0);
    check(rd, IMD_CTRL_RESET, "ctrl");
    xfer(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0, "hole");
    hold(5'h01);
    check(cmd.run, 1, "run");
    check(cmd.use_preset, 0, "ana");
    hold(5'h03);
    check(cmd.reverse, 1, "rev");
    hold(5'h05);
    check(cmd.reverse, 0, "fwd");
    check(cmd.use_preset, 1, "pre");
    xfer(1'b0, IMD_STATUS_ADDR, 32'h0);
    check(rd[1:0], 1, "state");
    hold(5'h04);
    check(cmd.run, 0, "stop");
    xfer(1'b0, IMD_INPUT_ADDR, 32'h0);
    check(rd[4:0], 5'h04, "ins");
    want <= 5'h05;
    @(posedge hclk);
    hold(5'h04);
    check(cmd.run, 0, "glitch");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h60);
    xfer(1'b0, IMD_CTRL_ADDR, 32'h0);
    check(rd, 32'h60, "ctrlrd");
    hold(5'h00);
    hold(5'h04);
    check(cmd.trip_code, IMD_TRIP_EXT, "trip");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h8860);
    hold(5'h00);
    hold(5'h04);
    check(cmd.trip_code, IMD_TRIP_THERM, "therm");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h8050);
    hold(5'h01);
    check({cmd.run, cmd.reverse}, 2'h2, "rfwd");
    hold(5'h00);
    check(cmd.run, 0, "rstop");
    hold(5'h02);
    check({cmd.run, cmd.reverse}, 2'h3, "rrev");
    catch_fast(5'h03);
    check(fs, 1, "fast");
    hold(5'h00);
    xfer(1'b1, IMD_CTRL_ADDR, 32'hA0);
    hold(5'h01);
    hold(5'h02);
    check(cmd.run, 0, "nostart");
    hold(5'h03);
    hold(5'h02);
    check(cmd.run, 1, "start");
    hold(5'h00);
    hold(5'h02);
    check(cmd.run, 0, "nstop");
    hold(5'h03);
    hold(5'h01);
    hold(5'h03);
    check(cmd.run, 0, "held");
    hold(5'h0B);
    check(cmd.run, 1, "pair");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h90);
    hold(5'h04);
    hold(5'h05);
    hold(5'h04);
    check({cmd.run, cmd.reverse}, 2'h2, "sfwd");
    hold(5'h00);
    hold(5'h04);
    check(cmd.run, 0, "s9stop");
    hold(5'h06);
    hold(5'h04);
    check({cmd.run, cmd.reverse}, 2'h3, "srev");
    hold(5'h0C);
    catch_fast(5'h04);
    check(fs, 1, "nfast");
    check(cmd.run, 0, "fsrun");
    hold(5'h00);
    xfer(1'b1, IMD_CTRL_ADDR, 32'h601);
    hold(5'h10);
    check(cmd.run, 1, "kpd");
    check(cmd.kpd_speed, 1, "kspd");
    hold(5'h00);
    xfer(1'b1, IMD_CTRL_ADDR, 32'h1);
    hold(5'h10);
    check(cmd.run, 0, "kwait");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h1001);
    hold(5'h10);
    check(cmd.run, 1, "kkey");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h2001);
    hold(5'h10);
    check(cmd.run, 0, "kstop");
    hold(5'h00);
    xfer(1'b1, IMD_CTRL_ADDR, 32'h4002);
    hold(5'h10);
    check(cmd.run, 0, "fbnoen");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h4002);
    hold(5'h10);
    check(cmd.run, 1, "fbrun");
    check(cmd.kpd_speed, 0, "kspd0");
    hresetn <= 1'b0;
    want <= 5'h01;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    hold(5'h01);
    check(cmd.run, 0, "noauto");
    xfer(1'b1, IMD_CTRL_ADDR, 32'h100);
    hold(5'h01);
    check(cmd.run, 1, "auto");
    finish_test;
  end
endmodule : tb
